// *** src/bpc_defines.svh ***
/*
 Named offsets, field positions and reset values of the port block.
 Assumes an 8-bit register address and 8-bit register data.
*/
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH

// Register offsets
`define BPC_ADDR_PORT     8'h06
`define BPC_ADDR_INTCTL   8'h0b
`define BPC_ADDR_OPTION   8'h81
`define BPC_ADDR_DIR      8'h86

// Reset values
`define BPC_RST_OPTION    8'hff
`define BPC_RST_DIR       8'hff
`define BPC_RST_LATCH     8'h00
`define BPC_RST_ZERO      8'h00

// Field positions
`define BPC_PULLUP_BIT    7
`define BPC_FLAG_BIT      0
`define BPC_CHG_LO        4
`define BPC_CHG_HI        7
`define BPC_EXT_INT_BIT   0
`define BPC_PROG_CLK_BIT  6
`define BPC_PROG_DATA_BIT 7

// Port and change-detect widths
`define BPC_PORT_W        8
`define BPC_CHG_W         4

`endif

// *** src/bpc_pkg.sv ***
/*
 Types shared by the port block: register request and access kinds.
 Assumes bpc_defines.svh is on the include path.
*/
`include "bpc_defines.svh"

package bpc_pkg;

    // Kind of register write: plain store or single-bit change
    typedef enum logic [1:0]
    {
        BPC_OP_WRITE,
        BPC_OP_BSET,
        BPC_OP_BCLR
    } bpc_op_type;

    // One register access from the CPU, valid for one cycle
    typedef struct packed
    {
        logic [7:0] addr;     // Register offset
        logic       rd;       // Read strobe
        logic       wr;       // Write strobe
        bpc_op_type op;       // Write kind
        logic [2:0] bit_sel;  // Bit for set or clear
        logic [7:0] wdata;    // Data for plain write
    } bpc_req_type;

endpackage

// *** src/bpc_pin_cell.sv ***
/*
 One port pin: output driver enable, output level and weak pull-up.
 Assumes the direction and latch bits come from registers.
*/
`timescale 1ns/1ps

module bpc_pin_cell
(
    input  wire logic i_latch,        // Output latch bit
    input  wire logic i_dir,          // One means input
    input  wire logic i_pullup_on,    // Global pull-up enable
    input  wire logic i_force_input,  // Alternate function owns the pin
    output logic      o_out,          // Level driven when enabled
    output logic      o_oe,           // High while the pin is driven
    output logic      o_pullup        // Weak pull-up active
);

    wire is_input;                    // Effective input mode

    // Alternate function also releases the driver
    assign is_input = i_dir | i_force_input;
    // Tri-state when input, else drive from latch
    assign o_oe     = ~is_input;      // [RL2]
    assign o_out    = i_latch;        // [RL2]
    // Pull-up only on inputs, with global enable
    assign o_pullup = i_pullup_on & is_input;  // [RL4]

endmodule

// *** src/bpc_change_detect.sv ***
/*
 Change detector on the upper pins: reference latch, mismatch and flag.
 Assumes the capture strobe marks every port read or write.
*/
`timescale 1ns/1ps

module bpc_change_detect
#(
    parameter int WIDTH = 4
)
(
    input  wire logic             i_sys_clk,   // Instruction clock
    input  wire logic             i_reset_n,   // Async reset, low
    input  wire logic             i_clk_en,    // Freeze when low
    input  wire logic [WIDTH-1:0] i_pins,      // Current pin levels
    input  wire logic [WIDTH-1:0] i_dir,       // One means input
    input  wire logic             i_capture,   // Port accessed
    input  wire logic             i_sw_we,     // Software writes flag
    input  wire logic             i_sw_val,    // Written flag value
    output logic                  o_flag,      // Change flag
    output logic                  o_mismatch   // Mismatch this cycle
);

    logic [WIDTH-1:0] ref_q;          // Value seen at last access
    logic [WIDTH-1:0] ref_d;
    logic             flag_q;         // Sticky change flag
    logic             flag_d;
    wire  [WIDTH-1:0] diff;           // Per-pin mismatch

    // Only input pins take part in the comparison
    assign diff       = (i_pins ^ ref_q) & i_dir;  // [RL6] [RL7]
    // Any differing pin raises the mismatch
    assign o_mismatch = |diff;                     // [RL8]
    // Reference follows the pins on each access
    assign ref_d      = i_capture ? i_pins : ref_q;  // [RL10]
    // Mismatch sets every cycle and beats a clear
    assign flag_d     = o_mismatch | (i_sw_we ? i_sw_val : flag_q);  // [RL11] [RL19]
    assign o_flag     = flag_q;

    // Reference and flag registers
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ref_q  <= '0;
            flag_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            ref_q  <= ref_d;
            flag_q <= flag_d;
        end
    end

endmodule

// *** src/bpc_port.sv ***
/*
 Eight-bit bidirectional port with pull-ups and change detection.
 Holds the latch, direction, option and interrupt-control registers,
 the register access logic and the pin drivers.
 Assumes one register request per instruction cycle, one clock per
 instruction cycle, and pin inputs synchronous to the clock.
*/
`timescale 1ns/1ps

`include "bpc_defines.svh"

// How it works
// [RL1] Eight pins, each input or output alone
// [RL2] Direction one tri-states, zero drives latch
// [RL3] Option bit seven low enables all pull-ups
// [RL4] Output pins never get the pull-up
// [RL5] Pull-ups start disabled after power-on
// [RL6] Only upper input pins are compared
// [RL7] Compare pins against value captured on read
// [RL8] ORed mismatches set the change flag
// [RL9] Change event can wake from sleep
// [RL10] Port access refreshes reference, then clear flag
// [RL11] Persisting mismatch keeps setting the flag
// [RL12] Read returns pins, write updates latches
// [RL13] Writes read pins, modify, store all latches
// [RL14] Write at cycle end, read at start
// [RL15] Software spaces port write and read
// [RL16] Software avoids polling during change detection
// [RL17] Bit zero interrupt, bits six seven programming
// [RL18] Every reset makes all pins inputs
// [RL19] Flag sticks until cleared without mismatch
module bpc_port
    import bpc_pkg::*;
#(
    parameter int PORT_W = `BPC_PORT_W,
    parameter int CHG_W  = `BPC_CHG_W
)
(
    input  wire logic              i_sys_clk,         // Instruction clock
    input  wire logic              i_reset_n,         // Async reset, low
    input  wire logic              i_clk_en,          // Freeze when low
    input  wire bpc_req_type       i_req,             // Register request
    output logic [7:0]             o_reg_rdata,       // Read data
    output logic                   o_reg_rvalid,      // Read data valid
    input  wire logic [PORT_W-1:0] i_pin_in,          // Pin levels
    output logic [PORT_W-1:0]      o_pin_out,         // Pin drive level
    output logic [PORT_W-1:0]      o_pin_oe,          // Pin drive enable
    output logic [PORT_W-1:0]      o_pullup_en,       // Weak pull-ups
    input  wire logic              i_prog_mode,       // Serial programming
    output logic                   o_ext_int_in,      // External interrupt
    output logic                   o_prog_clk,        // Programming clock
    output logic                   o_prog_data,       // Programming data
    output logic                   o_change_int_flag, // Change flag
    output logic                   o_wake_req         // Wake from sleep
);

    // Register state
    logic [PORT_W-1:0] latch_q;       // Output latches
    logic [PORT_W-1:0] latch_d;
    logic [PORT_W-1:0] dir_q;         // One means input
    logic [PORT_W-1:0] dir_d;
    logic [7:0]        option_q;      // Option register
    logic [7:0]        option_d;
    logic [7:0]        rdata_q;       // Registered read data
    logic [7:0]        rdata_d;
    logic              rvalid_q;      // Read answer marker
    logic              ext_int_q;     // Sampled interrupt pin
    logic              prog_clk_q;    // Sampled programming clock
    logic              prog_data_q;   // Sampled programming data
    logic              wake_q;        // Registered wake request

    // Address decode
    wire               hit_port;      // Port data selected
    wire               hit_dir;       // Direction selected
    wire               hit_option;    // Option selected
    wire               hit_intctl;    // Interrupt control selected
    wire               port_access;   // Any read or write of port

    // Read-modify-write path
    wire [7:0]         cur_val;       // Value read before modify
    wire [7:0]         new_val;       // Value after modify
    wire [7:0]         bit_mask;      // One-hot bit of bit ops
    wire [7:0]         intctl_val;    // Interrupt control view
    wire [7:0]         pin_view;      // Pin levels, zero extended

    // Pin control
    wire               pullup_on;     // Global pull-up enable
    wire [PORT_W-1:0]  force_in;      // Alternate function inputs
    wire               chg_flag;      // Flag from detector
    wire               chg_mismatch;  // Mismatch from detector
    wire               intctl_we;     // Software writes flag

    // Match an address against one register offset
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] offset);
        addr_hit = (addr == offset);
    endfunction

    // One-hot mask for single-bit operations
    function automatic logic [7:0] bit_to_mask(input logic [2:0] sel);
        bit_to_mask = 8'h01 << sel;
    endfunction

    // Decode of the four registers
    assign hit_port    = addr_hit(i_req.addr, `BPC_ADDR_PORT);
    assign hit_dir     = addr_hit(i_req.addr, `BPC_ADDR_DIR);
    assign hit_option  = addr_hit(i_req.addr, `BPC_ADDR_OPTION);
    assign hit_intctl  = addr_hit(i_req.addr, `BPC_ADDR_INTCTL);

    // Both reads and writes of the port refresh the reference
    assign port_access = hit_port & (i_req.rd | i_req.wr);  // [RL10] [RL7]

    // Interrupt control shows only the change flag
    assign intctl_val  = {7'h00, chg_flag};

    // Pins sampled at the start of the cycle
    assign pin_view    = 8'(i_pin_in);  // [RL14]

    // Value that a read sees: pins for the port, not the latches
    assign cur_val = hit_port   ? pin_view :       // [RL12]
                     hit_dir    ? 8'(dir_q) :
                     hit_option ? option_q :
                     hit_intctl ? intctl_val :
                                  `BPC_RST_ZERO;   // Unmapped reads zero

    // Modify step of every write
    assign bit_mask = bit_to_mask(i_req.bit_sel);
    assign new_val  = (i_req.op == BPC_OP_BSET) ? (cur_val | bit_mask) :
                      (i_req.op == BPC_OP_BCLR) ? (cur_val & ~bit_mask) :
                                                  i_req.wdata;  // [RL13]

    // Latches take the whole modified byte, inputs included
    assign latch_d  = (i_req.wr && hit_port) ? new_val[PORT_W-1:0]
                                             : latch_q;  // [RL13] [RL12]

    // Direction register write
    assign dir_d    = (i_req.wr && hit_dir) ? new_val[PORT_W-1:0] : dir_q;

    // Option register write
    assign option_d = (i_req.wr && hit_option) ? new_val : option_q;

    // Flag write through interrupt control
    assign intctl_we = i_req.wr & hit_intctl;

    // Read data for the answer in the next cycle
    assign rdata_d  = i_req.rd ? cur_val : rdata_q;

    // Pull-up control bit is active low
    assign pullup_on = ~option_q[`BPC_PULLUP_BIT];  // [RL3]

    // Programming mode takes over the two upper pins as inputs
    assign force_in = PORT_W'({i_prog_mode, i_prog_mode, 6'h00});  // [RL17]

    // Per-pin drivers and pull-ups
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi = gi + 1)
        begin : g_pin
            // Each bit has its own direction and latch
            bpc_pin_cell u_cell
            (
                .i_latch       (latch_q[gi]),    // [RL1]
                .i_dir         (dir_q[gi]),
                .i_pullup_on   (pullup_on),
                .i_force_input (force_in[gi]),
                .o_out         (o_pin_out[gi]),
                .o_oe          (o_pin_oe[gi]),
                .o_pullup      (o_pullup_en[gi])
            );
        end
    endgenerate

    // Change detector on the upper four pins
    bpc_change_detect
    #(
        .WIDTH (CHG_W)
    )
    u_change
    (
        .i_sys_clk  (i_sys_clk),
        .i_reset_n  (i_reset_n),
        .i_clk_en   (i_clk_en),
        .i_pins     (i_pin_in[`BPC_CHG_HI:`BPC_CHG_LO]),  // [RL6]
        .i_dir      (dir_q[`BPC_CHG_HI:`BPC_CHG_LO]),
        .i_capture  (port_access),
        .i_sw_we    (intctl_we),
        .i_sw_val   (new_val[`BPC_FLAG_BIT]),
        .o_flag     (chg_flag),
        .o_mismatch (chg_mismatch)
    );

    // Configuration registers: all pins input, pull-ups off
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            dir_q    <= PORT_W'(`BPC_RST_DIR);  // [RL18]
            option_q <= `BPC_RST_OPTION;        // [RL5]
        end
        else if (i_clk_en)
        begin
            dir_q    <= dir_d;
            option_q <= option_d;
        end
    end

    // Output latches, stored at the end of the cycle
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            latch_q <= PORT_W'(`BPC_RST_LATCH);
        end
        else if (i_clk_en)
        begin
            latch_q <= latch_d;  // [RL14]
        end
    end

    // Read answer registers
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdata_q  <= `BPC_RST_ZERO;
            rvalid_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= i_req.rd;
        end
    end

    // Alternate-function taps and wake request
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ext_int_q   <= 1'b0;
            prog_clk_q  <= 1'b0;
            prog_data_q <= 1'b0;
            wake_q      <= 1'b0;
        end
        else if (i_clk_en)
        begin
            // Bit zero feeds the external interrupt logic
            ext_int_q   <= i_pin_in[`BPC_EXT_INT_BIT];  // [RL17]
            // Upper pins feed the programmer only in that mode
            prog_clk_q  <= i_prog_mode & i_pin_in[`BPC_PROG_CLK_BIT];
            prog_data_q <= i_prog_mode & i_pin_in[`BPC_PROG_DATA_BIT];
            // Any mismatch or pending flag asks for wake-up
            wake_q      <= chg_mismatch | chg_flag;  // [RL9]
        end
    end

    // Outputs
    assign o_reg_rdata       = rdata_q;
    assign o_reg_rvalid      = rvalid_q;
    assign o_ext_int_in      = ext_int_q;
    assign o_prog_clk        = prog_clk_q;
    assign o_prog_data       = prog_data_q;
    assign o_change_int_flag = chg_flag;  // [RL8]
    assign o_wake_req        = wake_q;

endmodule

// *** verif/bpc_port_props.sv ***
/*
 Checker for the port block: ties pins, latches and flag to register traffic.
 Assumes it is bound to bpc_port and sees only that module's ports.
*/
`timescale 1ns/1ps

module bpc_port_props
    import bpc_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int CHG_W  = 4
)
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_clk_en,
    input  wire bpc_req_type       i_req,
    input  wire logic [7:0]        o_reg_rdata,
    input  wire logic              o_reg_rvalid,
    input  wire logic [PORT_W-1:0] i_pin_in,
    input  wire logic [PORT_W-1:0] o_pin_out,
    input  wire logic [PORT_W-1:0] o_pin_oe,
    input  wire logic [PORT_W-1:0] o_pullup_en,
    input  wire logic              i_prog_mode,
    input  wire logic              o_ext_int_in,
    input  wire logic              o_prog_clk,
    input  wire logic              o_prog_data,
    input  wire logic              o_change_int_flag,
    input  wire logic              o_wake_req
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    // Any write to the interrupt control register
    wire flag_wr = i_clk_en & i_req.wr & (i_req.addr == 8'h0b);

    // Taken port read
    sequence s_port_read;
        i_clk_en && i_req.rd && i_req.addr == 8'h06;
    endsequence
    // Taken plain port write
    sequence s_port_write;
        i_clk_en && i_req.wr && i_req.addr == 8'h06 && i_req.op == BPC_OP_WRITE;
    endsequence
    // Taken option write that turns pull-ups on
    sequence s_opt_low;
        i_clk_en && i_req.wr && i_req.addr == 8'h81 && i_req.op == BPC_OP_WRITE
            && !i_req.wdata[7];
    endsequence

    a_reset_all_inputs: assert property ($rose(i_reset_n) |->
        o_pin_oe == 8'h00 && o_pullup_en == 8'h00 && !o_change_int_flag)
        else $error("outputs not at reset state");
    a_no_output_pullup: assert property ((o_pullup_en & o_pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_option_pullup_on: assert property (s_opt_low |=> o_pullup_en == ~o_pin_oe)
        else $error("pull-ups not on for input pins");
    a_dir_sets_drive: assert property (i_clk_en && i_req.wr && i_req.addr == 8'h86
        && i_req.op == BPC_OP_WRITE && !i_prog_mode |=>
        i_prog_mode || o_pin_oe == ~$past(i_req.wdata))
        else $error("drive enable does not follow direction");
    a_write_sets_latch: assert property (s_port_write |=>
        o_pin_out == $past(i_req.wdata))
        else $error("port write did not reach latches");
    a_read_gives_pins: assert property (s_port_read |=>
        o_reg_rvalid && o_reg_rdata == $past(i_pin_in))
        else $error("port read did not return pins");
    a_rvalid_only_read: assert property (i_clk_en && !i_req.rd |=> !o_reg_rvalid)
        else $error("read valid without read");
    a_flag_stays_set: assert property (o_change_int_flag && !flag_wr |=>
        o_change_int_flag)
        else $error("change flag dropped by itself");
    a_flag_wakes_up: assert property (o_change_int_flag && i_clk_en |=> o_wake_req)
        else $error("no wake request while flag set");
    a_ext_int_follows: assert property (i_clk_en |=>
        o_ext_int_in == $past(i_pin_in[0]))
        else $error("interrupt input not from pin zero");
endmodule

bind bpc_port bpc_port_props #(.PORT_W(PORT_W), .CHG_W(CHG_W)) bpc_port_props_inst
(
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_req(i_req),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_pin_in(i_pin_in),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en),
    .i_prog_mode(i_prog_mode), .o_ext_int_in(o_ext_int_in), .o_prog_clk(o_prog_clk),
    .o_prog_data(o_prog_data), .o_change_int_flag(o_change_int_flag),
    .o_wake_req(o_wake_req)
);

// *** verif/bpc_pin_model.sv ***
/*
 Board around the port pins: external drivers, pull-ups and floating nets.
 Assumes the bench sets the external drive enable and level.
*/
`timescale 1ns/1ps

module bpc_pin_model
(
    input  wire logic       i_sys_clk,  // Clock for the floating pattern
    input  wire logic [7:0] i_out,      // Device drive level
    input  wire logic [7:0] i_oe,       // Device drive enable
    input  wire logic [7:0] i_pullup,   // Device weak pull-ups
    input  wire logic [7:0] i_ext_val,  // External drive level
    input  wire logic [7:0] i_ext_en,   // External drive enable
    output logic [7:0]      o_pin       // Resolved pin level
);
    logic float_q = 1'h0;  // Toggles so a floating pin never looks stable

    // Floating pattern advances each cycle
    always_ff @(posedge i_sys_clk)
        float_q <= ~float_q;

    // Device drive wins, then external drive, then pull-up, else noise
    always_comb
        for (int i = 0; i < 8; i++)
            o_pin[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_val[i] :
                       i_pullup[i] ? 1'h1 : float_q ^ i[0];
endmodule

// *** verif/tb.sv ***
/*
 Self-checking bench for the port block: register traffic and pin levels.
 Assumes the pin model resolves pins and the checker is bound.
*/
`timescale 1ns/1ps

module tb;
    import bpc_pkg::*;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } bpc_row_type;

    logic        i_sys_clk;    // 10 MHz clock
    logic        i_reset_n;    // Async reset
    logic        i_clk_en;     // Run enable
    bpc_req_type i_req;        // Register request
    logic        i_prog_mode;  // Programming mode
    logic [7:0]  ext_val;      // External drive level
    logic [7:0]  ext_en;       // External drive enable
    wire  [7:0]  pins, rdata, pout, oe, pu;
    wire         rvalid, ext_int, pclk, pdata, flag, wake;
    int          bad_count;
    int          check_count;
    // Write then read back: address, data, expected
    bpc_row_type rows [5] = '{'{8'h86, 8'ha5, 8'ha5}, '{8'h81, 8'h3c, 8'h3c},
        '{8'h40, 8'hff, 8'h00}, '{8'h0b, 8'hfe, 8'h00}, '{8'h86, 8'hff, 8'hff}};

    bpc_port bpc_port_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en), .i_req(i_req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_pin_in(pins), .o_pin_out(pout), .o_pin_oe(oe), .o_pullup_en(pu),
        .i_prog_mode(i_prog_mode), .o_ext_int_in(ext_int), .o_prog_clk(pclk),
        .o_prog_data(pdata), .o_change_int_flag(flag), .o_wake_req(wake));
    bpc_pin_model bpc_pin_model_inst (.i_sys_clk(i_sys_clk), .i_out(pout), .i_oe(oe),
        .i_pullup(pu), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin(pins));

    // Clock generator
    initial
    begin
        i_sys_clk = 1'h0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    // Compare one byte, count and report
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One request held for one edge, then idle
    task automatic access(input logic [7:0] a, input logic r, input logic w,
                          input bpc_op_type op, input logic [2:0] b, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_req <= '{a, r, w, op, b, d};
        @(posedge i_sys_clk);
        i_req <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(a, 1'h0, 1'h1, BPC_OP_WRITE, 3'h0, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        access(a, 1'h1, 1'h0, BPC_OP_WRITE, 3'h0, 8'h00);
        chk("rvalid", 8'h01, {7'h0, rvalid});
        chk("rdata", e, rdata);
    endtask

    // New external drive at a clock edge
    task automatic pins_set(input logic [7:0] en, input logic [7:0] val);
        @(posedge i_sys_clk);
        ext_en <= en;
        ext_val <= val;
    endtask

    // Counts, verdict, end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog far beyond the expected run
    initial
    begin
        #(3000 * 100);
        bad_count++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        i_reset_n = 1'h0;
        i_clk_en = 1'h1;
        i_req = '0;
        i_prog_mode = 1'h0;
        ext_val = 8'h00;
        ext_en = 8'hff;
        bad_count = 0;
        check_count = 0;
        repeat (16) @(posedge i_sys_clk);
        i_reset_n <= 1'h1;
        #1;
        chk("oe", 8'h00, oe);
        chk("pu", 8'h00, pu);
        rd(8'h86, 8'hff);
        rd(8'h81, 8'hff);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // Upper inputs float on pull-ups, lower pins driven
        wr(8'h86, 8'hf0);
        pins_set(8'h00, 8'h00);
        wr(8'h81, 8'h7f);
        chk("pu", 8'hf0, pu);
        chk("oe", 8'h0f, oe);
        rd(8'h06, 8'hf0);
        wr(8'h06, 8'h5a);
        chk("pout", 8'h5a, pout);
        rd(8'h06, 8'hfa);
        // Bit changes start from pin levels, not latches
        access(8'h06, 1'h0, 1'h1, BPC_OP_BCLR, 3'h7, 8'h00);
        chk("pout", 8'h7a, pout);
        access(8'h06, 1'h0, 1'h1, BPC_OP_BSET, 3'h2, 8'h00);
        chk("pout", 8'hfe, pout);
        wr(8'h81, 8'hff);
        chk("pu", 8'h00, pu);
        // Output and lower pins never raise the flag
        pins_set(8'hff, 8'h00);
        wr(8'h86, 8'h7f);
        wr(8'h06, 8'h00);
        rd(8'h06, 8'h00);
        wr(8'h0b, 8'h00);
        chk("flag", 8'h00, {7'h0, flag});
        wr(8'h06, 8'h80);
        pins_set(8'hff, 8'h02);
        repeat (3) @(posedge i_sys_clk);
        #1;
        chk("flag", 8'h00, {7'h0, flag});
        // Upper input change sets a flag that sticks
        wr(8'h86, 8'hff);
        rd(8'h06, 8'h02);
        pins_set(8'hff, 8'h22);
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk("flag", 8'h01, {7'h0, flag});
        chk("wake", 8'h01, {7'h0, wake});
        wr(8'h0b, 8'h00);
        chk("flag", 8'h01, {7'h0, flag});
        rd(8'h06, 8'h22);
        wr(8'h0b, 8'h00);
        chk("flag", 8'h00, {7'h0, flag});
        rd(8'h0b, 8'h00);
        // Programming mode takes the top two pins
        @(posedge i_sys_clk);
        i_prog_mode <= 1'h1;
        pins_set(8'hff, 8'h80);
        wr(8'h86, 8'h00);
        chk("oe", 8'h3f, oe);
        chk("pdata", 8'h01, {7'h0, pdata});
        chk("pclk", 8'h00, {7'h0, pclk});
        // Frozen clock enable ignores a direction write
        @(posedge i_sys_clk);
        i_clk_en <= 1'h0;
        wr(8'h86, 8'hff);
        chk("oe", 8'h3f, oe);
        @(posedge i_sys_clk);
        i_clk_en <= 1'h1;
        @(posedge i_sys_clk);
        i_prog_mode <= 1'h0;
        // Second reset in mid-run
        @(posedge i_sys_clk);
        i_reset_n <= 1'h0;
        @(posedge i_sys_clk);
        #1;
        chk("oe", 8'h00, oe);
        // Release on a rising edge, like every other input
        @(posedge i_sys_clk);
        i_reset_n <= 1'h1;
        rd(8'h86, 8'hff);
        stop_test();
    end
endmodule
